// ==== mvdec_dec_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface mvdec_dec_if;
    mvdec_pkg::mvdec_kind_t kind;
    logic byte_mode;
    logic [15:0] word_literal;
    logic [3:0] dst_work_reg;
    logic [3:0] src_work_reg;
    logic [3:0] shared_offset_reg;
    mvdec_pkg::mvdec_am_t dst_mode;
    mvdec_pkg::mvdec_am_t src_mode;
    logic [15:0] signed_offset_ten;

    modport producer (
        output kind, byte_mode, word_literal, dst_work_reg, src_work_reg,
        output shared_offset_reg, dst_mode, src_mode, signed_offset_ten
    );
    modport consumer (
        input kind, byte_mode, word_literal, dst_work_reg, src_work_reg,
        input shared_offset_reg, dst_mode, src_mode, signed_offset_ten
    );
endinterface

`default_nettype wire

// ==== mvdec_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mvdec_params.svh"

module mvdec_decode (
    // Instruction word
    input wire logic [23:0] instr,
    // Decoded fields
    mvdec_dec_if.producer dec
);

    always_comb begin
        logic [9:0] slit;
        logic [7:0] byte_literal;
        slit = {instr[18:15], instr[13:11], instr[6:4]};
        byte_literal = instr[11:4];
        dec.kind = mvdec_pkg::kind_none;
        dec.byte_mode = 1'b0;
        dec.word_literal = 16'h0000;
        dec.dst_work_reg = instr[10:7];
        dec.src_work_reg = instr[3:0];
        dec.shared_offset_reg = instr[18:15];
        dec.dst_mode = mvdec_pkg::am_direct;
        dec.src_mode = mvdec_pkg::am_direct;
        dec.signed_offset_ten = 16'h0000;
        if (instr[23:12] == `MVDEC_OPC_BLIT) begin
            dec.kind = mvdec_pkg::kind_blit;
            dec.byte_mode = 1'b1;
            dec.word_literal = {8'h00, byte_literal};
            dec.dst_work_reg = instr[3:0];
        end else if (instr[23:20] == `MVDEC_OPC_WLIT) begin
            dec.kind = mvdec_pkg::kind_wlit;
            dec.word_literal = instr[19:4];
            dec.dst_work_reg = instr[3:0];
        end else if (instr[23:20] == `MVDEC_OPC_OFS) begin
            dec.kind = instr[19] ? mvdec_pkg::kind_store : mvdec_pkg::kind_load;
            dec.byte_mode = instr[14];
            if (instr[14]) begin
                dec.signed_offset_ten = {{6{slit[9]}}, slit};
            end else begin
                dec.signed_offset_ten = {{5{slit[9]}}, slit, 1'b0};
            end
        end else if (instr[23:20] == `MVDEC_OPC_GEN) begin
            dec.kind = mvdec_pkg::kind_move;
            dec.byte_mode = instr[14];
            dec.dst_mode = mvdec_pkg::mvdec_am_t'(instr[13:11]);
            dec.src_mode = mvdec_pkg::mvdec_am_t'(instr[6:4]);
        end
    end

endmodule

`default_nettype wire

// ==== mvdec_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module mvdec_mem (
    // Clock
    input wire logic pclk,
    // Read port
    input wire logic mem_re,
    input wire logic [15:0] mem_raddr,
    output logic [15:0] mem_rdata,
    // Write port
    input wire logic [1:0] mem_we,
    input wire logic [15:0] mem_waddr,
    input wire logic [15:0] mem_wdata
);
    logic [15:0] m [32768];
    logic [15:0] last = 16'h0000;

    // Idle read port shows the inverted last read word
    assign mem_rdata = mem_re ? m[mem_raddr[15:1]] : ~last;

    always @(posedge pclk) begin
        if (mem_re) begin
            last <= m[mem_raddr[15:1]];
        end
        if (mem_we[0]) begin
            m[mem_waddr[15:1]][7:0] <= mem_wdata[7:0];
        end
        if (mem_we[1]) begin
            m[mem_waddr[15:1]][15:8] <= mem_wdata[15:8];
        end
    end
endmodule

`default_nettype wire

// ==== mvdec_params.svh ====
`ifndef MVDEC_PARAMS_SVH
`define MVDEC_PARAMS_SVH

// Register byte offsets on the APB
`define MVDEC_OFF_INSTR 12'h000
`define MVDEC_OFF_STAT 12'h004
`define MVDEC_OFF_SR 12'h008
`define MVDEC_OFF_WREG 12'h040

// Reset values
`define MVDEC_RST_WREG 16'h0000
`define MVDEC_RST_SR 16'h0000
`define MVDEC_RST_INSTR 24'h000000

// Opcode prefixes
`define MVDEC_OPC_BLIT 12'hb3c
`define MVDEC_OPC_WLIT 4'h2
`define MVDEC_OPC_OFS 4'h9
`define MVDEC_OPC_GEN 4'h7

// Stack pointer index and pointer steps
`define MVDEC_SP_IDX 4'hf
`define MVDEC_STEP_BYTE 16'h0001
`define MVDEC_STEP_WORD 16'h0002

// Status register field positions
`define MVDEC_STAT_ILL 0
`define MVDEC_STAT_MIS 1
`define MVDEC_STAT_PUSH 2
`define MVDEC_STAT_POP 3
`define MVDEC_STAT_BUSY 4
`define MVDEC_STAT_KIND 8
`define MVDEC_STAT_CNT 16

`endif

// ==== mvdec_pkg.sv ====
package mvdec_pkg;

    typedef enum logic [2:0] {
        kind_none = 3'h0,
        kind_blit = 3'h1,
        kind_wlit = 3'h2,
        kind_load = 3'h3,
        kind_store = 3'h4,
        kind_move = 3'h5
    } mvdec_kind_t;

    typedef enum logic [2:0] {
        am_direct = 3'h0,
        am_ind = 3'h1,
        am_postdec = 3'h2,
        am_postinc = 3'h3,
        am_predec = 3'h4,
        am_preinc = 3'h5,
        am_ofs = 3'h6,
        am_ofs_alt = 3'h7
    } mvdec_am_t;

    typedef struct packed {
        logic [15:0][15:0] wreg;
        logic [23:0] instr;
        logic exec;
        logic [15:0] sr;
        logic illegal;
        logic misalign;
        logic push_seen;
        logic pop_seen;
        mvdec_kind_t last_kind;
        logic [15:0] count;
        logic [1:0] mwe;
        logic [15:0] mwaddr;
        logic [15:0] mwdata;
    } mvdec_state_t;

endpackage

// ==== mvdec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mvdec_params.svh"

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, mem_re, ok;
    logic [1:0] mem_we;
    logic [15:0] mem_raddr, mem_rdata, mem_waddr, mem_wdata;
    logic [15:0] lfsr = 16'h97d8;
    logic [15:0] wm [16] = '{default: 16'h0};
    logic [2:0] cc = 3'h0;
    int mismatches = 0;
    int comparisons = 0;
    int cnt = 0;

    mvdec_top i_dut (.*);
    mvdec_mem i_mem (.*);

    always #4 pclk = ~pclk;

    // Clock enable drops one cycle in eight
    always @(posedge pclk) begin
        cc <= cc + 3'h1;
        ce <= (cc != 3'h5);
    end

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [23:0] ofs(input logic st, bm, input logic [9:0] k,
                                        input logic [3:0] d, s);
        return {4'h9, st, k[9:6], bm, k[5:3], d, k[2:0], s};
    endfunction
    function automatic logic [23:0] mv(input logic [3:0] w, input logic bm,
                                       input logic [2:0] dm, input logic [3:0] d,
                                       input logic [2:0] sm, input logic [3:0] s);
        return {4'h7, 1'b1, w, bm, dm, d, sm, s};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        ok = pready;
        rd = prdata;
        err = pslverr;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: bus timeout", $time);
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic exec(input logic [23:0] i);
        apb(1'b1, `MVDEC_OFF_INSTR, {8'h00, i});
        cnt++;
    endtask
    task automatic setw(input logic [3:0] n, input logic [15:0] v);
        exec({4'h2, v, n});
        wm[n] = v;
    endtask
    task automatic chkw(input logic [3:0] n);
        apb(1'b0, `MVDEC_OFF_WREG + {6'h0, n, 2'b00}, 32'h0);
        chk(rd, {16'h0, wm[n]}, "working register");
    endtask

    initial begin
        logic [15:0] v, b, ea, p, st;
        logic [9:0] k;
        logic [3:0] d;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `MVDEC_OFF_SR, 32'h0000a5c3);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            d = v[3:0];
            v = (i == 0) ? 16'hfc18 : rnd();
            setw(d, v);
            b = (i == 0) ? 16'h00ff : rnd();
            exec({`MVDEC_OPC_BLIT, b[7:0], d});
            wm[d][7:0] = b[7:0];
            chkw(d);
        end
        $display("literal test done");
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            k = (i == 0) ? 10'h200 : (i == 1) ? 10'h1ff : v[9:0];
            setw(4'h1, {4'h4, v[11:1], 1'b0});
            setw(4'h2, rnd());
            exec(ofs(1'b1, 1'b0, k, 4'h1, 4'h2));
            exec(ofs(1'b0, 1'b0, k, 4'h3, 4'h1));
            wm[3] = wm[2];
            chkw(4'h3);
            ea = wm[1] + {{5{k[9]}}, k, 1'b0};
            chk(i_mem.m[ea[15:1]], wm[2], "word store");
            exec(ofs(1'b1, 1'b1, k, 4'h1, 4'h2));
            exec(ofs(1'b0, 1'b1, k, 4'h4, 4'h1));
            wm[4][7:0] = wm[2][7:0];
            chkw(4'h4);
            ea = wm[1] + {{6{k[9]}}, k};
            b = i_mem.m[ea[15:1]] >> (ea[0] ? 8 : 0);
            chk(b[7:0], wm[2][7:0], "byte store");
        end
        $display("offset test done");
        setw(4'h5, rnd());
        for (int m = 1; m < 6; m++) begin
            for (int bm = 0; bm < 2; bm++) begin
                st = bm[0] ? 16'h1 : 16'h2;
                p = 16'h3000 + ((m == 2 || m == 4) ? -st : (m == 1) ? 16'h0 : st);
                setw(4'h8, 16'h3000);
                exec(mv(4'h0, bm[0], m[2:0], 4'h8, 3'h0, 4'h5));
                wm[8] = p;
                chkw(4'h8);
                setw(4'h8, 16'h3000);
                exec(mv(4'h0, bm[0], 3'h0, 4'h9, m[2:0], 4'h8));
                wm[9] = bm[0] ? {wm[9][15:8], wm[5][7:0]} : wm[5];
                chkw(4'h9);
            end
        end
        exec(mv(4'h0, 1'b1, 3'h0, 4'hd, 3'h0, 4'h5));
        wm[13][7:0] = wm[5][7:0];
        chkw(4'hd);
        setw(4'hf, 16'h2000);
        exec(mv(4'h0, 1'b0, 3'h3, 4'hf, 3'h0, 4'h5));
        exec(mv(4'h0, 1'b0, 3'h0, 4'h6, 3'h4, 4'hf));
        wm[6] = wm[5];
        chkw(4'h6);
        chkw(4'hf);
        apb(1'b0, `MVDEC_OFF_STAT, 32'h0);
        chk(rd[10:2], 9'h143, "push pop status");
        apb(1'b1, `MVDEC_OFF_STAT, 32'h0000000c);
        apb(1'b0, `MVDEC_OFF_STAT, 32'h0);
        chk(rd[3:2], 2'b00, "status clear");
        setw(4'ha, 16'h3100);
        setw(4'hb, 16'h0040);
        setw(4'hc, 16'h3200);
        exec(mv(4'hb, 1'b0, 3'h6, 4'ha, 3'h0, 4'h5));
        exec(mv(4'hb, 1'b0, 3'h6, 4'hc, 3'h7, 4'ha));
        chkw(4'ha);
        chk(i_mem.m[15'h1920], wm[5], "shared offset");
        $display("move test done");
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped read");
        apb(1'b0, `MVDEC_OFF_SR, 32'h0);
        chk(rd, 32'h0000a5c3, "status register");
        setw(4'h7, 16'h3001);
        exec(24'h000000);
        exec(ofs(1'b0, 1'b0, 10'h000, 4'h6, 4'h7));
        apb(1'b0, `MVDEC_OFF_STAT, 32'h0);
        chk(rd[31:16], cnt[15:0], "executed count");
        chk({rd[10:8], rd[1:0]}, 5'h0f, "error flags");
        $display("register test done");
        report_and_stop();
    end
endmodule

`default_nettype wire

// ==== mvdec_top.sv ====
// Functional notes
// - Byte literal load decoded from 1011_0011_1100 prefix, literal, destination.
// - Byte literal 0..255 replaces only the destination low byte.
// - Word literal load: prefix 0010, sixteen-bit literal, destination selector.
// - Offset load reads memory at base plus signed ten-bit offset, doubled for word transfers.
// - Offset store differs in one bit and writes source to memory.
// - General move decodes offset, byte bit, modes and register selectors.
// - One shared offset register serves both source and destination.
// - Push is post-increment store, pop pre-decrement load, via stack pointer.
// - Byte/word bit set selects byte transfer, clear selects word.
`timescale 1ns/1ps
`default_nettype none
`include "mvdec_params.svh"

module mvdec_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data memory read port, answered in the same cycle
    output logic mem_re,
    output logic [15:0] mem_raddr,
    input wire logic [15:0] mem_rdata,
    // Data memory write port, byte lanes
    output logic [1:0] mem_we,
    output logic [15:0] mem_waddr,
    output logic [15:0] mem_wdata
);

    localparam mvdec_pkg::mvdec_state_t RST = '{
        wreg: {16{`MVDEC_RST_WREG}},
        instr: `MVDEC_RST_INSTR,
        sr: `MVDEC_RST_SR,
        last_kind: mvdec_pkg::kind_none,
        default: '0
    };

    mvdec_pkg::mvdec_state_t s_q;
    mvdec_pkg::mvdec_state_t s_d;

    mvdec_dec_if dec ();

    mvdec_decode u_decode (
        .instr(s_q.instr),
        .dec(dec.producer)
    );

    // Effective address of an operand
    function automatic logic [15:0] am_ea(
        input mvdec_pkg::mvdec_am_t m,
        input logic [15:0] base,
        input logic [15:0] step,
        input logic [15:0] ofs
    );
        logic [15:0] r;
        r = base;
        unique case (m)
            mvdec_pkg::am_direct,
            mvdec_pkg::am_ind,
            mvdec_pkg::am_postdec,
            mvdec_pkg::am_postinc: r = base;
            mvdec_pkg::am_predec: r = base - step;
            mvdec_pkg::am_preinc: r = base + step;
            mvdec_pkg::am_ofs,
            mvdec_pkg::am_ofs_alt: r = base + ofs;
        endcase
        return r;
    endfunction

    // Pointer value after the access
    function automatic logic [15:0] am_next(
        input mvdec_pkg::mvdec_am_t m,
        input logic [15:0] base,
        input logic [15:0] step
    );
        logic [15:0] r;
        r = base;
        unique case (m)
            mvdec_pkg::am_postinc,
            mvdec_pkg::am_preinc: r = base + step;
            mvdec_pkg::am_postdec,
            mvdec_pkg::am_predec: r = base - step;
            mvdec_pkg::am_direct,
            mvdec_pkg::am_ind,
            mvdec_pkg::am_ofs,
            mvdec_pkg::am_ofs_alt: r = base;
        endcase
        return r;
    endfunction

    function automatic logic is_mem(input mvdec_pkg::mvdec_am_t m);
        return m != mvdec_pkg::am_direct;
    endfunction

    // Operand values seen by the executing instruction
    logic [15:0] step;
    logic [15:0] src_rv;
    logic [15:0] dst_rv;
    logic [15:0] wofs;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [15:0] rd_val;
    logic [15:0] src_val;

    always_comb begin
        step = dec.byte_mode ? `MVDEC_STEP_BYTE : `MVDEC_STEP_WORD;
        src_rv = s_q.wreg[dec.src_work_reg];
        dst_rv = s_q.wreg[dec.dst_work_reg];
        wofs = s_q.wreg[dec.shared_offset_reg];
        src_ea = am_ea(dec.src_mode, src_rv, step, wofs);
        dst_ea = am_ea(dec.dst_mode, dst_rv, step, wofs);
        mem_re = 1'b0;
        mem_raddr = 16'h0000;
        if (s_q.exec && ce) begin
            if (dec.kind == mvdec_pkg::kind_load) begin
                mem_re = 1'b1;
                mem_raddr = src_rv + dec.signed_offset_ten;
            end else if (dec.kind == mvdec_pkg::kind_move && is_mem(dec.src_mode)) begin
                mem_re = 1'b1;
                mem_raddr = src_ea;
            end
        end
        if (dec.byte_mode) begin
            rd_val = {8'h00, mem_raddr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
        end else begin
            rd_val = mem_rdata;
        end
        if (dec.kind == mvdec_pkg::kind_move && !is_mem(dec.src_mode)) begin
            src_val = dec.byte_mode ? {8'h00, src_rv[7:0]} : src_rv;
        end else begin
            src_val = rd_val;
        end
    end

    // Next state
    always_comb begin
        logic access;
        logic [3:0] widx;
        logic [15:0] wr_val;
        logic [3:0] wr_idx;
        logic wr_en;
        logic [15:0] st_addr;
        logic [15:0] st_val;
        logic st_en;
        access = psel && penable && pready;
        widx = paddr[5:2];
        wr_val = 16'h0000;
        wr_idx = dec.dst_work_reg;
        wr_en = 1'b0;
        st_addr = 16'h0000;
        st_val = 16'h0000;
        st_en = 1'b0;
        s_d = s_q;
        if (ce) begin
            s_d.mwe = 2'b00;
            if (access && pwrite) begin
                if (paddr == `MVDEC_OFF_INSTR) begin
                    s_d.instr = pwdata[23:0];
                    s_d.exec = 1'b1;
                end else if (paddr == `MVDEC_OFF_STAT) begin
                    if (pwdata[`MVDEC_STAT_ILL]) s_d.illegal = 1'b0;
                    if (pwdata[`MVDEC_STAT_MIS]) s_d.misalign = 1'b0;
                    if (pwdata[`MVDEC_STAT_PUSH]) s_d.push_seen = 1'b0;
                    if (pwdata[`MVDEC_STAT_POP]) s_d.pop_seen = 1'b0;
                end else if (paddr == `MVDEC_OFF_SR) begin
                    s_d.sr = pwdata[15:0];
                end else if (paddr[11:6] == `MVDEC_OFF_WREG >> 6 && paddr[1:0] == 2'b00) begin
                    s_d.wreg[widx] = pwdata[15:0];
                end
            end
            // single execute cycle, may set the illegal, misalign, push and pop status flags
            if (s_q.exec) begin
                s_d.exec = 1'b0;
                s_d.last_kind = dec.kind;
                s_d.count = s_q.count + 16'h0001;
                unique case (dec.kind)
                    mvdec_pkg::kind_none: begin
                        s_d.illegal = 1'b1;
                    end
                    mvdec_pkg::kind_blit,
                    mvdec_pkg::kind_wlit: begin
                        wr_en = 1'b1;
                        wr_val = dec.word_literal;
                    end
                    mvdec_pkg::kind_load: begin
                        wr_en = 1'b1;
                        wr_val = rd_val;
                    end
                    mvdec_pkg::kind_store: begin
                        st_en = 1'b1;
                        st_addr = dst_rv + dec.signed_offset_ten;
                        st_val = src_rv;
                    end
                    mvdec_pkg::kind_move: begin
                        s_d.wreg[dec.src_work_reg] = am_next(dec.src_mode, src_rv, step);
                        s_d.wreg[dec.dst_work_reg] = am_next(dec.dst_mode, dst_rv, step);
                        if (dec.dst_work_reg == `MVDEC_SP_IDX
                            && dec.dst_mode == mvdec_pkg::am_postinc) begin
                            s_d.push_seen = 1'b1;
                        end
                        if (dec.src_work_reg == `MVDEC_SP_IDX
                            && dec.src_mode == mvdec_pkg::am_predec) begin
                            s_d.pop_seen = 1'b1;
                        end
                        if (is_mem(dec.dst_mode)) begin
                            st_en = 1'b1;
                            st_addr = dst_ea;
                            st_val = src_val;
                        end else begin
                            wr_en = 1'b1;
                            wr_val = src_val;
                        end
                    end
                endcase
                if (wr_en) begin
                    if (dec.byte_mode) begin
                        s_d.wreg[wr_idx][7:0] = wr_val[7:0];
                    end else begin
                        s_d.wreg[wr_idx] = wr_val;
                    end
                end
                if (st_en) begin
                    s_d.mwaddr = {st_addr[15:1], 1'b0};
                    if (dec.byte_mode) begin
                        s_d.mwe = st_addr[0] ? 2'b10 : 2'b01;
                        s_d.mwdata = {st_val[7:0], st_val[7:0]};
                    end else begin
                        s_d.mwe = 2'b11;
                        s_d.mwdata = st_val;
                    end
                end
                if (!dec.byte_mode && ((st_en && st_addr[0]) || (mem_re && mem_raddr[0]))) begin
                    s_d.misalign = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    // APB answer and read data
    always_comb begin
        logic hit;
        hit = 1'b1;
        prdata = 32'h00000000;
        if (paddr == `MVDEC_OFF_INSTR) begin
            prdata = {8'h00, s_q.instr};
        end else if (paddr == `MVDEC_OFF_STAT) begin
            prdata[`MVDEC_STAT_ILL] = s_q.illegal;
            prdata[`MVDEC_STAT_MIS] = s_q.misalign;
            prdata[`MVDEC_STAT_PUSH] = s_q.push_seen;
            prdata[`MVDEC_STAT_POP] = s_q.pop_seen;
            prdata[`MVDEC_STAT_BUSY] = s_q.exec;
            prdata[`MVDEC_STAT_KIND +: 3] = s_q.last_kind;
            prdata[`MVDEC_STAT_CNT +: 16] = s_q.count;
        end else if (paddr == `MVDEC_OFF_SR) begin
            prdata = {16'h0000, s_q.sr};
        end else if (paddr[11:6] == `MVDEC_OFF_WREG >> 6 && paddr[1:0] == 2'b00) begin
            prdata = {16'h0000, s_q.wreg[paddr[5:2]]};
        end else begin
            hit = 1'b0;
        end
        pready = ce && !s_q.exec;
        pslverr = psel && penable && !hit;
    end

    assign mem_we = ce ? s_q.mwe : 2'b00;
    assign mem_waddr = s_q.mwaddr;
    assign mem_wdata = s_q.mwdata;

endmodule

`default_nettype wire

// ==== mvdec_top_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module mvdec_top_monitor (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Memory
    input wire logic mem_re,
    input wire logic [15:0] mem_raddr,
    input wire logic [1:0] mem_we,
    input wire logic [15:0] mem_waddr,
    input wire logic [15:0] mem_wdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr;
        psel && penable && pready && pwrite && paddr == 12'h000;
    endsequence
    sequence s_lit;
        s_wr ##0 (pwdata[23:12] == 12'hb3c || pwdata[23:20] == 4'h2);
    endsequence

    property p_one_cycle;
        s_wr |=> !pready;
    endproperty
    property p_exec_done;
        ce && !pready |=> pready || !ce;
    endproperty
    property p_lit_nomem;
        s_lit |=> !mem_re ##1 mem_we == 2'b00;
    endproperty
    property p_load_reads;
        s_wr ##0 pwdata[23:19] == 5'h12 |=> mem_re || !ce;
    endproperty
    property p_store_noread;
        s_wr ##0 pwdata[23:19] == 5'h13 |=> !mem_re;
    endproperty
    property p_re_exec;
        mem_re |-> ce && !pready;
    endproperty
    property p_raddr_idle;
        !mem_re |-> mem_raddr == 16'h0000;
    endproperty
    property p_we_single;
        mem_we != 2'b00 |=> mem_we == 2'b00;
    endproperty
    property p_we_align;
        mem_we != 2'b00 |-> !mem_waddr[0] && ce;
    endproperty
    property p_byte_lanes;
        mem_we == 2'b01 || mem_we == 2'b10 |-> mem_wdata[15:8] == mem_wdata[7:0];
    endproperty

    a_one_cycle: assert property (p_one_cycle)
        else $error("no execute cycle after instruction write");
    a_exec_done: assert property (p_exec_done)
        else $error("execution took more than one cycle");
    a_lit_nomem: assert property (p_lit_nomem)
        else $error("literal load touched memory");
    a_load_reads: assert property (p_load_reads)
        else $error("offset load did not read memory");
    a_store_noread: assert property (p_store_noread)
        else $error("offset store read memory");
    a_re_exec: assert property (p_re_exec)
        else $error("memory read outside execute cycle");
    a_raddr_idle: assert property (p_raddr_idle)
        else $error("read address not zero while idle");
    a_we_single: assert property (p_we_single)
        else $error("write pulse longer than one cycle");
    a_we_align: assert property (p_we_align)
        else $error("write address odd or write while frozen");
    a_byte_lanes: assert property (p_byte_lanes)
        else $error("byte write data not replicated");
endmodule

bind mvdec_top mvdec_top_monitor i_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .mem_re(mem_re), .mem_raddr(mem_raddr), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));

`default_nettype wire
